// *** verilog/irqst_pkg.sv ***
// package: register map, field positions and carriers of the interrupt-request and error-status block
package irqst_pkg;
    // register indices and byte addresses, one word each
    localparam int unsigned IRQST_IDX_COMM_REQ = 4;
    localparam int unsigned IRQST_IDX_MISC_REQ = 5;
    localparam int unsigned IRQST_IDX_ERRORS = 6;
    localparam int unsigned IRQST_IDX_COMM_EN = 8;
    localparam int unsigned IRQST_IDX_MISC_EN = 9;
    localparam int unsigned IRQST_IDX_CTRL = 10;
    localparam int unsigned IRQST_IDX_STATUS = 11;
    localparam logic [7:0] IRQST_ADDR_COMM_REQ = 8'(IRQST_IDX_COMM_REQ * 4);
    localparam logic [7:0] IRQST_ADDR_MISC_REQ = 8'(IRQST_IDX_MISC_REQ * 4);
    localparam logic [7:0] IRQST_ADDR_ERRORS = 8'(IRQST_IDX_ERRORS * 4);
    localparam logic [7:0] IRQST_ADDR_COMM_EN = 8'(IRQST_IDX_COMM_EN * 4);
    localparam logic [7:0] IRQST_ADDR_MISC_EN = 8'(IRQST_IDX_MISC_EN * 4);
    localparam logic [7:0] IRQST_ADDR_CTRL = 8'(IRQST_IDX_CTRL * 4);
    localparam logic [7:0] IRQST_ADDR_STATUS = 8'(IRQST_IDX_STATUS * 4);
    // reset values
    localparam logic [7:0] IRQST_COMM_REQ_RST = 8'h14;
    localparam logic [7:0] IRQST_MISC_REQ_RST = 8'h00;
    localparam logic [7:0] IRQST_ERRORS_RST = 8'h00;
    localparam logic [7:0] IRQST_COMM_EN_RST = 8'h80;
    localparam logic [7:0] IRQST_MISC_EN_RST = 8'h00;
    localparam logic [7:0] IRQST_CTRL_RST = 8'h00;
    // field positions
    localparam int unsigned IRQST_POLARITY_BIT = 7;
    localparam int unsigned IRQST_INVERT_BIT = 7;
    localparam logic [7:0] IRQST_COMM_REQ_MASK = 8'h7f;
    localparam logic [7:0] IRQST_MISC_REQ_MASK = 8'h0f;
    localparam logic [7:0] IRQST_COMM_EN_MASK = 8'h7f;
    localparam logic [7:0] IRQST_MISC_EN_MASK = 8'h0f;
    localparam logic [7:0] IRQST_ERRORS_MASK = 8'h9f;
    localparam int unsigned IRQST_CTRL_RX_ONLY_BYTES = 0;
    localparam int unsigned IRQST_CTRL_RX_CHECKSUM = 1;
    localparam int unsigned IRQST_CTRL_FAST_RATE = 2;
    // command codes
    localparam logic [3:0] IRQST_CMD_IDLE = 4'h0;
    // axi responses
    localparam logic [1:0] IRQST_RESP_OKAY = 2'b00;
    localparam logic [1:0] IRQST_RESP_SLVERR = 2'b10;

    // events from the transmitter and receiver
    typedef struct packed {
        logic tx_last_bit_sent;
        logic rx_valid_end;
        logic fifo_has_bytes;
        logic rx_startup;
        logic bit_collision;
        logic checksum_fail;
        logic parity_fail;
        logic sof_wrong;
        logic miller_short_pulses;
    } irqst_rf_s;

    // events from the command sequencer, fifo, timer and detectors
    typedef struct packed {
        logic cmd_self_end;
        logic cmd_unknown_start;
        logic auto_anticollision_command;
        logic initiator_set;
        logic host_fifo_write;
        logic between_tx_rx_last;
        logic fifo_full_write;
        logic fifo_high_live;
        logic fifo_low_live;
        logic countdown_zero;
        logic data_mode_found;
        logic checksum_done;
        logic field_present;
    } irqst_core_s;
endpackage

// *** verilog/irqst_top.sv ***
// interrupt-request and error-status registers behind an axi4-lite slave
// Contract
// - comm request write: bit 7 high sets, low clears, each bit written as 1.
// - misc request write: bit 7 picks set or clear for bits written as 1.
// - transmit flag bit 6 set when last outgoing bit leaves the transmitter.
// - receive flag bit 5 set at end of a valid incoming stream.
// - with receive-only-with-bytes on, receive flag needs fifo bytes present.
// - command-finished flag bit 4 set when a command ends by itself.
// - unknown command returns to idle and sets flag; host idle does not.
// - fifo high flag bit 3 latched on rising live high alert.
// - fifo low flag bit 2 latched on rising live low alert.
// - any-fault flag bit 1 set whenever any stored error bit is set, fast-rate bit 3 excluded.
// - countdown flag bit 0 set when timer reaches zero.
// - data-mode flag bit 3 set when mode detector reports under anticollision.
// - checksum-done flag bit 2 set when checksum command finished its data.
// - field-appeared flag bit 1 set when external field becomes detected.
// - field-vanished flag bit 0 set when a present field disappears.
// - write-misuse fault bit 7 on host fifo write in anticollision or tx-rx gap.
// - overflow fault bit 4 on any write into a full fifo.
// - collision fault bit 3 on collision, cleared at rx start, fixed 1 at fast rates.
// - checksum fault bit 2 when checking enabled and failed, cleared at rx start.
// - parity fault bit 1 on parity failure, cleared at rx start.
// - framing fault bit 0 on bad start, initiator in anticollision, or short pulses.
// - pending status true when any enabled request flag is set.
// - interrupt pin equals pending status, inverted when invert bit is 1.
`timescale 1ns/1ps
`default_nettype none

module irqst_top (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // frontend events, same clock
    input wire irqst_pkg::irqst_rf_s rf_events,
    input wire irqst_pkg::irqst_core_s core_events,
    // outputs
    output logic return_to_idle,
    output logic pending_any,
    output logic irq_pin
);
    import irqst_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] comm_interrupt_requests;
    logic [7:0] misc_interrupt_requests;
    logic [7:0] last_command_errors;
    logic [7:0] comm_enable;
    logic [7:0] misc_enable;
    logic [7:0] block_control;
    logic fifo_high_prev;
    logic fifo_low_prev;
    logic field_prev;

    // axi write bookkeeping
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_lane0;

    ////////////////////////////////////////////////////////////////////////////
    // axi write channels: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane0 = wr_fire && w_strb[0];

    // capture address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // capture data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= IRQST_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
                IRQST_ADDR_COMM_REQ, IRQST_ADDR_MISC_REQ, IRQST_ADDR_ERRORS,
                IRQST_ADDR_COMM_EN, IRQST_ADDR_MISC_EN, IRQST_ADDR_CTRL,
                IRQST_ADDR_STATUS: s_axi_bresp <= IRQST_RESP_OKAY;
                default: s_axi_bresp <= IRQST_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event detection
    logic live_high_rise;
    logic live_low_rise;
    logic field_rise;
    logic field_fall;
    logic rx_event;
    logic [7:0] comm_set;
    logic [7:0] misc_set;
    logic [7:0] err_set;
    logic [7:0] err_clear;
    logic fast_rate;

    assign live_high_rise = core_events.fifo_high_live && !fifo_high_prev;
    assign live_low_rise = core_events.fifo_low_live && !fifo_low_prev;
    assign field_rise = core_events.field_present && !field_prev;
    assign field_fall = !core_events.field_present && field_prev;
    assign fast_rate = block_control[IRQST_CTRL_FAST_RATE];
    // receive end, gated on fifo bytes if asked
    assign rx_event = rf_events.rx_valid_end
        && (!block_control[IRQST_CTRL_RX_ONLY_BYTES] || rf_events.fifo_has_bytes);

    // unknown command start forces idle
    assign return_to_idle = core_events.cmd_unknown_start;

    // last samples of level inputs for edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifo_high_prev <= 1'b0;
            fifo_low_prev <= 1'b0;
            field_prev <= 1'b0;
        end else begin
            fifo_high_prev <= core_events.fifo_high_live;
            fifo_low_prev <= core_events.fifo_low_live;
            field_prev <= core_events.field_present;
        end
    end

    // request set vectors
    always_comb begin
        comm_set = 8'h00;
        comm_set[6] = rf_events.tx_last_bit_sent;
        comm_set[5] = rx_event;
        comm_set[4] = core_events.cmd_self_end || core_events.cmd_unknown_start;
        comm_set[3] = live_high_rise;
        comm_set[2] = live_low_rise;
        comm_set[1] = |last_command_errors;
        comm_set[0] = core_events.countdown_zero;
        misc_set = 8'h00;
        misc_set[3] = core_events.data_mode_found && core_events.auto_anticollision_command;
        misc_set[2] = core_events.checksum_done;
        misc_set[1] = field_rise;
        misc_set[0] = field_fall;
    end

    // fault set and start-up clear vectors
    always_comb begin
        err_set = 8'h00;
        err_set[7] = core_events.host_fifo_write
            && (core_events.auto_anticollision_command || core_events.between_tx_rx_last);
        err_set[4] = core_events.fifo_full_write;
        err_set[3] = rf_events.bit_collision;
        err_set[2] = rf_events.checksum_fail && block_control[IRQST_CTRL_RX_CHECKSUM];
        err_set[1] = rf_events.parity_fail;
        err_set[0] = rf_events.sof_wrong || rf_events.miller_short_pulses
            || (core_events.auto_anticollision_command && core_events.initiator_set);
        err_clear = 8'h00;
        if (rf_events.rx_startup) begin
            err_clear[3:0] = 4'hf;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // communication request register: mask write, hardware set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comm_interrupt_requests <= IRQST_COMM_REQ_RST;
        end else begin
            if (wr_lane0 && aw_addr == IRQST_ADDR_COMM_REQ) begin
                if (w_data[IRQST_POLARITY_BIT]) begin
                    comm_interrupt_requests <= (comm_interrupt_requests
                        | (w_data[7:0] & IRQST_COMM_REQ_MASK) | comm_set);
                end else begin
                    comm_interrupt_requests <= (comm_interrupt_requests
                        & ~(w_data[7:0] & IRQST_COMM_REQ_MASK)) | comm_set;
                end
            end else begin
                comm_interrupt_requests <= comm_interrupt_requests | comm_set;
            end
        end
    end

    // miscellaneous request register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            misc_interrupt_requests <= IRQST_MISC_REQ_RST;
        end else begin
            if (wr_lane0 && aw_addr == IRQST_ADDR_MISC_REQ) begin
                if (w_data[IRQST_POLARITY_BIT]) begin
                    misc_interrupt_requests <= (misc_interrupt_requests
                        | (w_data[7:0] & IRQST_MISC_REQ_MASK) | misc_set);
                end else begin
                    misc_interrupt_requests <= (misc_interrupt_requests
                        & ~(w_data[7:0] & IRQST_MISC_REQ_MASK)) | misc_set;
                end
            end else begin
                misc_interrupt_requests <= misc_interrupt_requests | misc_set;
            end
        end
    end

    // error register: read only; set wins over start-up clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_command_errors <= IRQST_ERRORS_RST;
        end else begin
            last_command_errors <= ((last_command_errors & ~err_clear) | err_set)
                & IRQST_ERRORS_MASK;
        end
    end

    // enable and control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comm_enable <= IRQST_COMM_EN_RST;
            misc_enable <= IRQST_MISC_EN_RST;
            block_control <= IRQST_CTRL_RST;
        end else if (wr_lane0) begin
            case (aw_addr)
                IRQST_ADDR_COMM_EN: comm_enable <= w_data[7:0];
                IRQST_ADDR_MISC_EN: misc_enable <= w_data[7:0] & IRQST_MISC_EN_MASK;
                IRQST_ADDR_CTRL: block_control <= w_data[7:0];
                default: comm_enable <= comm_enable;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending status and pin
    assign pending_any = |(comm_interrupt_requests & comm_enable & IRQST_COMM_EN_MASK)
        || |(misc_interrupt_requests & misc_enable & IRQST_MISC_EN_MASK);
    assign irq_pin = pending_any ^ comm_enable[IRQST_INVERT_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // read channel: data one cycle after address
    logic [7:0] rd_byte;
    logic rd_hit;

    // read multiplexer
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            IRQST_ADDR_COMM_REQ: rd_byte = comm_interrupt_requests & IRQST_COMM_REQ_MASK;
            IRQST_ADDR_MISC_REQ: rd_byte = misc_interrupt_requests & IRQST_MISC_REQ_MASK;
            IRQST_ADDR_ERRORS: begin
                rd_byte = last_command_errors;
                rd_byte[3] = last_command_errors[3] | fast_rate;
            end
            IRQST_ADDR_COMM_EN: rd_byte = comm_enable;
            IRQST_ADDR_MISC_EN: rd_byte = misc_enable;
            IRQST_ADDR_CTRL: rd_byte = block_control;
            IRQST_ADDR_STATUS: rd_byte = {7'h00, pending_any};
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    // read data register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= IRQST_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? IRQST_RESP_OKAY : IRQST_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // irqst_top

`default_nettype wire

// *** bench/irqst_props.sv ***
// bus timing and pin checks of the request block
`timescale 1ns/1ps
`default_nettype none
module irqst_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire irqst_pkg::irqst_core_s core_events,
    input wire logic return_to_idle,
    input wire logic pending_any,
    input wire logic irq_pin
);
    import irqst_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    // both write channels taken at one edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // response low at the first edge after acceptance, high at the second
    sequence s_resp_late;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    a_write_resp_time: assert property (s_wr_taken |=> s_resp_late)
        else $error("late write response");
    a_read_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read data");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("response dropped early");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_idle_forced: assert property (return_to_idle == core_events.cmd_unknown_start)
        else $error("idle return mismatch");
    // pin and pending differ only by the invert bit, set by a write
    a_pin_invert: assert property (!$stable(irq_pin ^ pending_any) |-> $rose(s_axi_bvalid))
        else $error("pin polarity moved by itself");
endmodule // irqst_props
bind irqst_top irqst_props u_irqst_props (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .core_events, .return_to_idle,
    .pending_any, .irq_pin
);
`default_nettype wire

// *** bench/irqst_host.sv ***
// host model: axi4-lite master reading and clearing flags
`timescale 1ns/1ps
`default_nettype none
module irqst_host (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    output logic hung
);
    logic slow;
    // idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
        slow = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one write; every other call stalls the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        slow = !slow;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (n >= (slow ? 4 : 0)) s_axi_bready <= 1'b1;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 200) hung <= 1'b1;
    endtask
    // one read; every other call stalls the data
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        slow = !slow;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (n >= (slow ? 3 : 0)) s_axi_rready <= 1'b1;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 200) hung <= 1'b1;
    endtask
endmodule // irqst_host
`default_nettype wire

// *** bench/tb_top.sv ***
// testbench of the interrupt-request and error-status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import irqst_pkg::*;
    logic aclk, aresetn, hung, return_to_idle, pending_any, irq_pin;
    logic [7:0] s_axi_awaddr, s_axi_araddr, ce, me;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    irqst_rf_s rf_events, rp;
    irqst_core_s core_events, cp;
    int fail_count, n_tests;
    irqst_top u_irqst_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rf_events, .core_events,
        .return_to_idle, .pending_any, .irq_pin);
    irqst_host u_irqst_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hung);
    // 20 mhz clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // a host wait that ran out
    always @(posedge hung) begin
        fail_count++;
        end_of_test();
    end
    // compares for data, responses and flags
    task automatic chkd(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chkr(input logic [1:0] g, input logic [1:0] e);
        chkd(32'(g), 32'(e));
    endtask
    task automatic chkf(input logic g, input logic e);
        chkd(32'(g), 32'(e));
    endtask
    // bus calls expecting okay
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        u_irqst_host.rd(a, d, r);
        chkd(d, {24'h00_0000, e});
        chkr(r, IRQST_RESP_OKAY);
    endtask
    task automatic wrc(input logic [7:0] a, input logic [31:0] v);
        u_irqst_host.wr(a, v, 4'h1, r);
        chkr(r, IRQST_RESP_OKAY);
    endtask
    // one-cycle event pulse
    task automatic pulse(input irqst_rf_s p, input irqst_core_s c);
        @(posedge aclk);
        rf_events <= p;
        core_events <= c;
        @(posedge aclk);
        chkf(return_to_idle, c.cmd_unknown_start);
        rf_events <= '0;
        core_events <= '0;
    endtask
    // pulse, then read the errors
    task automatic step(input irqst_rf_s p, input irqst_core_s c, input logic [7:0] e);
        pulse(p, c);
        rdc(IRQST_ADDR_ERRORS, e);
    endtask
    // clear every request flag
    task automatic clr();
        wrc(IRQST_ADDR_COMM_REQ, 32'h0000_007f);
        wrc(IRQST_ADDR_MISC_REQ, 32'h0000_000f);
    endtask
    // mask-write model and random source
    function automatic logic [7:0] mw(input logic [7:0] o, input logic [31:0] v,
        input logic [7:0] m);
        return v[7] ? (o | (v[7:0] & m)) : (o & ~(v[7:0] & m));
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {aresetn, rf_events, core_events, fail_count, n_tests} = '0;
        seed = 32'h0000_6485;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(IRQST_ADDR_COMM_REQ, 8'h14);
        rdc(IRQST_ADDR_MISC_REQ, IRQST_MISC_REQ_RST);
        rdc(IRQST_ADDR_ERRORS, 8'h00);
        rdc(IRQST_ADDR_COMM_EN, IRQST_COMM_EN_RST);
        chkf(irq_pin, 1'b1);
        // unmapped, read-only and lane-0-off writes
        u_irqst_host.rd(8'h3c, d, r);
        chkr(r, IRQST_RESP_SLVERR);
        chkd(d, 32'h0000_0000);
        u_irqst_host.wr(8'h3c, 32'hffff_ffff, 4'hf, r);
        chkr(r, IRQST_RESP_SLVERR);
        wrc(IRQST_ADDR_ERRORS, 32'h0000_00ff);
        rdc(IRQST_ADDR_ERRORS, 8'h00);
        u_irqst_host.wr(IRQST_ADDR_COMM_REQ, 32'h0000_00ff, 4'h0, r);
        rdc(IRQST_ADDR_COMM_REQ, 8'h14);
        // random set and clear writes
        ce = 8'h14;
        me = 8'h00;
        repeat (24) begin
            seed = xs(seed);
            if (seed[9]) begin
                wrc(IRQST_ADDR_COMM_REQ, seed);
                ce = mw(ce, seed, 8'h7f);
                rdc(IRQST_ADDR_COMM_REQ, ce);
            end else begin
                wrc(IRQST_ADDR_MISC_REQ, seed);
                me = mw(me, seed, 8'h0f);
                rdc(IRQST_ADDR_MISC_REQ, me);
            end
        end
        // each event sets its own flag only
        for (int i = 0; i < 10; i++) begin
            clr();
            case (i)
                0: {rp, cp, ce, me} = {9'h100, 13'h0000, 8'h40, 8'h00};
                1: {rp, cp, ce, me} = {9'h080, 13'h0000, 8'h20, 8'h00};
                2: {rp, cp, ce, me} = {9'h000, 13'h1000, 8'h10, 8'h00};
                3: {rp, cp, ce, me} = {9'h000, 13'h0800, 8'h10, 8'h00};
                4: {rp, cp, ce, me} = {9'h000, 13'h0020, 8'h08, 8'h00};
                5: {rp, cp, ce, me} = {9'h000, 13'h0010, 8'h04, 8'h00};
                6: {rp, cp, ce, me} = {9'h000, 13'h0008, 8'h01, 8'h00};
                7: {rp, cp, ce, me} = {9'h000, 13'h0404, 8'h00, 8'h08};
                8: {rp, cp, ce, me} = {9'h000, 13'h0002, 8'h00, 8'h04};
                default: {rp, cp, ce, me} = {9'h000, 13'h0001, 8'h00, 8'h03};
            endcase
            pulse(rp, cp);
            repeat (3) @(posedge aclk);
            rdc(IRQST_ADDR_COMM_REQ, ce);
            rdc(IRQST_ADDR_MISC_REQ, me);
        end
        // receive flag needs fifo bytes when asked
        wrc(IRQST_ADDR_CTRL, 32'h0000_0001);
        clr();
        pulse(9'h080, 13'h0000);
        rdc(IRQST_ADDR_COMM_REQ, 8'h00);
        pulse(9'h0c0, 13'h0000);
        rdc(IRQST_ADDR_COMM_REQ, 8'h20);
        pulse(9'h000, 13'h0001);
        // enables and pin polarity against comm 0x20, misc 0x03
        for (int k = 0; k < 4; k++) begin
            wrc(IRQST_ADDR_MISC_EN, (k == 0) ? 32'h0000_0002 : 32'h0000_0008);
            wrc(IRQST_ADDR_COMM_EN, {24'h00_0000, (k == 1) ? 8'h20 : (k == 2) ? 8'hc0 : 8'h40});
            chkf(pending_any, k < 2);
            chkf(irq_pin, (k < 2) ^ (k == 2));
            rdc(IRQST_ADDR_STATUS, {7'h00, k < 2});
        end
        // error register
        wrc(IRQST_ADDR_CTRL, 32'h0000_0000);
        step(9'h008, 13'h0000, 8'h00);
        wrc(IRQST_ADDR_CTRL, 32'h0000_0002);
        step(9'h008, 13'h0000, 8'h04);
        step(9'h010, 13'h0000, 8'h0c);
        step(9'h004, 13'h0000, 8'h0e);
        step(9'h002, 13'h0000, 8'h0f);
        step(9'h020, 13'h0000, 8'h00);
        step(9'h001, 13'h0000, 8'h01);
        step(9'h020, 13'h0000, 8'h00);
        step(9'h000, 13'h0600, 8'h01);
        wrc(IRQST_ADDR_CTRL, 32'h0000_0006);
        rdc(IRQST_ADDR_ERRORS, 8'h09);
        step(9'h000, 13'h0100, 8'h09);
        step(9'h000, 13'h0180, 8'h89);
        step(9'h000, 13'h0040, 8'h99);
        wrc(IRQST_ADDR_COMM_REQ, 32'h0000_0002);
        rdc(IRQST_ADDR_COMM_REQ, 8'h22);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
